// ==== hdl/ihr_params.svh ====
// Register offsets, field positions and reset values of the serial interrupt and holding block
`ifndef IHR_PARAMS_SVH
`define IHR_PARAMS_SVH

// Register byte offsets
`define IHR_OFF_IRQ_ENABLE     8'h24
`define IHR_OFF_IRQ_DISABLE    8'h28
`define IHR_OFF_IRQ_MASK       8'h2C
`define IHR_OFF_RX_HOLD        8'h30
`define IHR_OFF_TX_HOLD        8'h34
`define IHR_OFF_STATUS         8'h38
`define IHR_OFF_EVT_STATUS     8'h40
`define IHR_OFF_EVT_CLEAR      8'h44
`define IHR_OFF_EVT_ENABLE     8'h48

// Interrupt source bit positions
`define IHR_BIT_XFER_DONE      0
`define IHR_BIT_RX_READY       1
`define IHR_BIT_TX_READY       2
`define IHR_BIT_SLAVE_ACC      4
`define IHR_BIT_GEN_CALL       5
`define IHR_BIT_OVERRUN        6
`define IHR_BIT_NOT_ACK        8
`define IHR_BIT_ARB_LOST       9
`define IHR_BIT_CLK_STRETCH    10
`define IHR_BIT_END_SLAVE_ACC  11

// Implemented source bits
`define IHR_SRC_MASK           32'h0000_0F77

// Reset values
`define IHR_RST_MASK           12'h000
`define IHR_RST_HOLD           8'h00
`define IHR_RST_WORD           32'h0000_0000

`endif

// ==== hdl/ihr_pkg.sv ====
// Types shared by the serial interrupt and holding block
package ihr_pkg;

    // Register bus request from software
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ihr_bus_req_t;

    // Status flags from the protocol engine, one per source bit
    typedef logic [11:0] ihr_src_t;

endpackage

// ==== hdl/ihr_regs.sv ====
// Interrupt mask, holding registers and event interrupt of the two-wire serial unit
// Register map, byte offsets on the 8-bit register address:
//   0x24  interrupt enable     write-only, ones set mask bits
//   0x28  interrupt disable    write-only, ones clear mask bits, reads zero
//   0x2C  interrupt mask       read-only, one per enabled source
//   0x30  receive holding      read-only, last received byte in bits 7..0
//   0x34  transmit holding     read-write, next byte to send in bits 7..0
//   0x38  status               read-only, live flags; read clears local overrun
//   0x40  event status         read-only, sticky rising edges of the flags
//   0x44  event clear          write-only, ones clear event status bits
//   0x48  event enable         read-write, gates the event interrupt
//   Any other offset reads zero and ignores writes.
//
// Source bit layout shared by every interrupt-related register:
//   bit 0   transfer_complete
//   bit 1   receive_ready
//   bit 2   transmit_ready
//   bit 3   reserved
//   bit 4   slave_access
//   bit 5   general_call_seen
//   bit 6   overrun_error
//   bit 7   reserved
//   bit 8   not-acknowledge
//   bit 9   arbitration_lost
//   bit 10  clock_stretch_wait
//   bit 11  end_of_slave_access
//   Bits 12 and up are reserved as well.
//
// Timing seen from the register bus:
//   A write takes effect at the edge that samples its strobe.
//   Read data stand only in the cycle after the read strobe, zero otherwise.
//   The block never stalls the bus; strobes may follow with no gap.
//   irq_o follows a flag or mask change one cycle later.
//   evt_irq_o follows the rising edge of a flag two cycles later.
//
// Shifter handshakes:
//   rx_load_i is a one-cycle pulse with the new byte on rx_byte_i.
//   tx_take_i is a one-cycle pulse when the shifter copies tx_byte_o.
//   tx_pending_o stays high from the holding write until that take.
//   A write in the take cycle keeps the new byte pending.
//
// Limitations and hazards:
//   Reserved bits are dropped on every write and read back as zero.
//   Enable and disable are separate strobes, so both never hit one cycle.
//   Transmit ready returns only when the shifter takes a pending byte.
//   Overrun is kept locally; the engine's own overrun level is ORed in.
//   A load in the read cycle of receive holding keeps receive ready set,
//   so the new byte is never silently lost.
//   All inputs come from logic on this clock; none is synchronised here.
//
// Implementation choices: the address map and the address-and-strobe port.
`include "ihr_params.svh"

module ihr_regs
    import ihr_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // Register bus
    input  wire ihr_bus_req_t bus_i,
    output logic [31:0]       rdata_o,
    // Status flags from the protocol engine, excluding receive and transmit ready
    input  wire ihr_src_t     engine_flags_i,
    // Receive byte handshake from the shifter
    input  wire logic         rx_load_i,
    input  wire logic [7:0]   rx_byte_i,
    // Transmit byte handshake to the shifter
    input  wire logic         tx_take_i,
    output logic [7:0]        tx_byte_o,
    output logic              tx_pending_o,
    // Interrupt outputs
    output logic              irq_o,
    output logic              evt_irq_o
);

    // Keep only implemented source bits
    function automatic logic [11:0] src_bits(input logic [31:0] w);
        logic [31:0] kept;
        kept     = w & `IHR_SRC_MASK;
        src_bits = kept[11:0];
    endfunction

    // Address compare used by every strobe decode; the read mux compares the address itself
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic [11:0] mask_reg;
    logic [7:0]  rx_hold_reg;
    logic [7:0]  tx_hold_reg;
    logic        rx_ready_reg;
    logic        tx_ready_reg;
    logic        overrun_reg;
    logic [11:0] evt_status_reg;
    logic [11:0] evt_enable_reg;
    logic [11:0] flags;
    logic [11:0] flags_q;
    logic [11:0] irq_src;

    // Strobes decoded once per register
    logic        wr_tx;
    logic        rd_rx;
    logic        wr_enable;
    logic        wr_disable;
    logic        wr_evt_clear;
    logic        wr_evt_enable;
    logic        rd_status;

    // One decode per register keeps the processes below, except the read mux, free of address logic
    assign wr_tx         = bus_i.wr && hit(bus_i.addr, `IHR_OFF_TX_HOLD);
    assign rd_rx         = bus_i.rd && hit(bus_i.addr, `IHR_OFF_RX_HOLD);
    assign wr_enable     = bus_i.wr && hit(bus_i.addr, `IHR_OFF_IRQ_ENABLE);
    assign wr_disable    = bus_i.wr && hit(bus_i.addr, `IHR_OFF_IRQ_DISABLE);
    assign wr_evt_clear  = bus_i.wr && hit(bus_i.addr, `IHR_OFF_EVT_CLEAR);
    assign wr_evt_enable = bus_i.wr && hit(bus_i.addr, `IHR_OFF_EVT_ENABLE);
    assign rd_status     = bus_i.rd && hit(bus_i.addr, `IHR_OFF_STATUS);

    // Live status: engine flags merged with locally kept ready and overrun flags
    always_comb begin
        flags = src_bits({20'h0_0000, engine_flags_i});
        flags[`IHR_BIT_RX_READY] = rx_ready_reg;
        flags[`IHR_BIT_TX_READY] = tx_ready_reg;
        flags[`IHR_BIT_OVERRUN]  = overrun_reg | engine_flags_i[`IHR_BIT_OVERRUN];
    end

    // Mask: enable sets, disable clears; enable wins if both hit same bit
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= `IHR_RST_MASK;
        end else if (wr_enable) begin
            mask_reg <= mask_reg | src_bits(bus_i.wdata);
        end else if (wr_disable) begin
            mask_reg <= mask_reg & ~src_bits(bus_i.wdata);
        end
    end

    // Receive holding; a new byte over an unread one flags overrun
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_hold_reg <= `IHR_RST_HOLD;
        end else if (rx_load_i) begin
            rx_hold_reg <= rx_byte_i;
        end
    end

    // Receive ready: a load in the read cycle keeps the flag set
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_ready_reg <= 1'b0;
        end else if (rx_load_i) begin
            rx_ready_reg <= 1'b1;
        end else if (rd_rx) begin
            rx_ready_reg <= 1'b0;
        end
    end

    // Overrun, cleared by a status read; a new overrun wins over the clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            overrun_reg <= 1'b0;
        end else if (rx_load_i && rx_ready_reg && !rd_rx) begin
            overrun_reg <= 1'b1;
        end else if (rd_status) begin
            overrun_reg <= 1'b0;
        end
    end

    // Transmit holding and its hand-over to the shifter
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_hold_reg <= `IHR_RST_HOLD;
        end else if (wr_tx) begin
            tx_hold_reg <= bus_i.wdata[7:0];
        end
    end

    // Pending byte for the shifter; a write in the take cycle stays pending
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pending_o <= 1'b0;
        end else if (wr_tx) begin
            tx_pending_o <= 1'b1;
        end else if (tx_take_i) begin
            tx_pending_o <= 1'b0;
        end
    end

    // Transmit ready: low on write, high once shifter took the byte
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_ready_reg <= 1'b1;
        end else if (wr_tx) begin
            tx_ready_reg <= 1'b0;
        end else if (tx_take_i && tx_pending_o) begin
            tx_ready_reg <= 1'b1;
        end
    end

    assign tx_byte_o = tx_hold_reg;

    // Rising edges of flags feed the sticky event register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= 12'h000;
        end else begin
            flags_q <= flags;
        end
    end

    // Sticky events: set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            evt_status_reg <= 12'h000;
        end else if (wr_evt_clear) begin
            evt_status_reg <= (evt_status_reg & ~src_bits(bus_i.wdata))
                              | (flags & ~flags_q);
        end else begin
            evt_status_reg <= evt_status_reg | (flags & ~flags_q);
        end
    end

    // Event enable register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            evt_enable_reg <= 12'h000;
        end else if (wr_evt_enable) begin
            evt_enable_reg <= src_bits(bus_i.wdata);
        end
    end

    // Enabled sources; kept as a vector so a probe can see which one fires
    assign irq_src = flags & mask_reg;

    // Interrupt outputs registered: irq_o one cycle behind the flags, evt_irq_o one behind event status
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o     <= 1'b0;
            evt_irq_o <= 1'b0;
        end else begin
            irq_o     <= |irq_src;
            evt_irq_o <= |(evt_status_reg & evt_enable_reg);
        end
    end

    // Read data one cycle after the strobe; write-only and unmapped read zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `IHR_RST_WORD;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                `IHR_OFF_IRQ_MASK:   rdata_o <= {20'h0_0000, mask_reg};
                `IHR_OFF_RX_HOLD:    rdata_o <= {24'h00_0000, rx_hold_reg};
                `IHR_OFF_TX_HOLD:    rdata_o <= {24'h00_0000, tx_hold_reg};
                `IHR_OFF_STATUS:     rdata_o <= {20'h0_0000, flags};
                `IHR_OFF_EVT_STATUS: rdata_o <= {20'h0_0000, evt_status_reg};
                `IHR_OFF_EVT_ENABLE: rdata_o <= {20'h0_0000, evt_enable_reg};
                default:             rdata_o <= `IHR_RST_WORD;
            endcase
        end else begin
            rdata_o <= `IHR_RST_WORD;
        end
    end

endmodule // ihr_regs

// ==== verif/ihr_regs_monitor.sv ====
// Port checker for the interrupt mask and holding registers
`include "ihr_params.svh"
module ihr_regs_monitor
    import ihr_pkg::*;
(
    // Clock, reset and bus
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire ihr_bus_req_t bus_i,
    input  wire logic [31:0]  rdata_o,
    // Shifter handshakes and interrupt
    input  wire logic         rx_load_i,
    input  wire logic [7:0]   rx_byte_i,
    input  wire logic         tx_take_i,
    input  wire logic [7:0]   tx_byte_o,
    input  wire logic         tx_pending_o,
    input  wire logic         irq_o
);
    logic [11:0] mask_reg;
    logic [7:0]  rx_reg;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Shadow of the mask, rebuilt from bus writes; reserved bits never stick
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= 12'h000;
        end else if (bus_i.wr && bus_i.addr == `IHR_OFF_IRQ_ENABLE) begin
            mask_reg <= mask_reg | (bus_i.wdata[11:0] & 12'hF77);
        end else if (bus_i.wr && bus_i.addr == `IHR_OFF_IRQ_DISABLE) begin
            mask_reg <= mask_reg & ~bus_i.wdata[11:0];
        end
    end
    // Shadow of the last received byte
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_reg <= 8'h00;
        end else if (rx_load_i) begin
            rx_reg <= rx_byte_i;
        end
    end
    a_mask_read_back: assert property (bus_i.rd && bus_i.addr == `IHR_OFF_IRQ_MASK
        |=> rdata_o == {20'h0_0000, $past(mask_reg)}) else $error("mask read wrong");
    a_disable_reads_zero: assert property (bus_i.rd && bus_i.addr == `IHR_OFF_IRQ_DISABLE
        |=> rdata_o == 32'h0000_0000) else $error("disable register not zero");
    a_rx_byte_read: assert property (bus_i.rd && bus_i.addr == `IHR_OFF_RX_HOLD
        |=> rdata_o == {24'h00_0000, $past(rx_reg)}) else $error("received byte wrong");
    a_tx_byte_load: assert property (bus_i.wr && bus_i.addr == `IHR_OFF_TX_HOLD
        |=> tx_pending_o && tx_byte_o == $past(bus_i.wdata[7:0])) else $error("tx byte lost");
    a_tx_ready_drop: assert property (bus_i.wr && bus_i.addr == `IHR_OFF_TX_HOLD ##1
        !tx_take_i ##1 (bus_i.rd && bus_i.addr == `IHR_OFF_STATUS && !tx_take_i)
        |=> !rdata_o[2]) else $error("transmit ready still set");
    a_rx_ready_clear: assert property (bus_i.rd && bus_i.addr == `IHR_OFF_RX_HOLD
        && !rx_load_i ##1 !rx_load_i [*2] ##1 (bus_i.rd && bus_i.addr == `IHR_OFF_STATUS)
        |=> !rdata_o[1]) else $error("receive ready not cleared");
    a_rx_ready_irq: assert property (rx_load_i && mask_reg[1]
        |-> ##2 irq_o) else $error("no interrupt for received byte");
    a_irq_quiet_masked: assert property (mask_reg == 12'h000
        && $past(mask_reg) == 12'h000 |-> !irq_o) else $error("interrupt while all masked");
endmodule // ihr_regs_monitor

bind ihr_regs ihr_regs_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .rx_load_i(rx_load_i), .rx_byte_i(rx_byte_i), .tx_take_i(tx_take_i),
    .tx_byte_o(tx_byte_o), .tx_pending_o(tx_pending_o), .irq_o(irq_o));

// ==== verif/ihr_regs_tb_top.sv ====
// Self-checking bench for the interrupt mask and holding registers
module ihr_regs_tb_top
    import ihr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] val;
    } ihr_row_t;
    logic         clk_sys_i, rst_i, rx_load_i, tx_take_i, tx_pending_o, irq_o;
    ihr_bus_req_t bus_i;
    ihr_src_t     engine_flags_i;
    logic [7:0]   rx_byte_i, tx_byte_o;
    logic         evt_irq_o;
    logic [31:0]  rdata_o, got;
    int           fails = 0;
    int           checks_done = 0;
    ihr_row_t     rows [14] = '{
        '{0, 8'h2C, 32'h0}, '{0, 8'h30, 32'h0}, '{0, 8'h34, 32'h0},
        '{1, 8'h24, 32'hFFFF_FFFF}, '{0, 8'h2C, 32'h0000_0F77},
        '{1, 8'h28, 32'h0000_0105}, '{0, 8'h2C, 32'h0000_0E72},
        '{0, 8'h28, 32'h0}, '{1, 8'h2C, 32'h0}, '{0, 8'h2C, 32'h0000_0E72},
        '{1, 8'h28, 32'hFFFF_FFFF}, '{0, 8'h2C, 32'h0},
        '{1, 8'h34, 32'h0000_01A5}, '{0, 8'h34, 32'h0000_00A5}};
    ihr_regs dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .engine_flags_i(engine_flags_i), .rx_load_i(rx_load_i), .rx_byte_i(rx_byte_i),
        .tx_take_i(tx_take_i), .tx_byte_o(tx_byte_o), .tx_pending_o(tx_pending_o),
        .irq_o(irq_o), .evt_irq_o(evt_irq_o));
    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // One-cycle strobes, launched just after an edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus_i.wr <= 1'b0;
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus_i.rd <= 1'b0;
        #1 got = rdata_o;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        bus_i = '0;
        engine_flags_i = '0;
        {rx_load_i, tx_take_i, rx_byte_i} = '0;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus_wr(rows[i].addr, rows[i].val);
            end else begin
                bus_rd(rows[i].addr);
                chk("register read", rows[i].val, got);
            end
        end
        $display("test register table done");
        // Byte lands, raises the interrupt, the read clears it
        bus_wr(8'h24, 32'h0000_0002);
        @(posedge clk_sys_i);
        rx_byte_i <= 8'h3C;
        rx_load_i <= 1'b1;
        @(posedge clk_sys_i);
        rx_load_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1 chk("irq", 32'h1, 32'(irq_o));
        bus_rd(8'h30);
        chk("rx byte", 32'h0000_003C, got);
        bus_rd(8'h38);
        chk("rx ready", 32'h0, got & 32'h0000_0002);
        chk("irq", 32'h0, 32'(irq_o));
        $display("test receive done");
        // Ready hidden while the byte waits; the take brings it back
        bus_wr(8'h34, 32'h0000_005A);
        bus_rd(8'h38);
        chk("tx ready", 32'h0, got & 32'h0000_0004);
        chk("tx byte", 32'h0000_005A, 32'(tx_byte_o));
        @(posedge clk_sys_i);
        tx_take_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_take_i <= 1'b0;
        bus_wr(8'h24, 32'h0000_0004);
        repeat (3) @(posedge clk_sys_i);
        #1 chk("irq", 32'h1, 32'(irq_o));
        chk("tx pending", 32'h0, 32'(tx_pending_o));
        bus_wr(8'h28, 32'h0000_0006);
        repeat (3) @(posedge clk_sys_i);
        #1 chk("irq", 32'h0, 32'(irq_o));
        $display("test transmit done");
        // Engine flag drives both interrupts; event clear drops the sticky one
        bus_wr(8'h24, 32'h0000_0001);
        bus_wr(8'h48, 32'h0000_0001);
        @(posedge clk_sys_i);
        engine_flags_i <= 12'h001;
        repeat (3) @(posedge clk_sys_i);
        #1 chk("irq", 32'h1, 32'(irq_o));
        chk("evt irq", 32'h1, 32'(evt_irq_o));
        @(posedge clk_sys_i);
        engine_flags_i <= 12'h000;
        bus_wr(8'h44, 32'h0000_0001);
        repeat (3) @(posedge clk_sys_i);
        #1 chk("evt irq", 32'h0, 32'(evt_irq_o));
        chk("irq", 32'h0, 32'(irq_o));
        bus_wr(8'h28, 32'h0000_0001);
        // Two bytes with no read between flag overrun at bit 6
        @(posedge clk_sys_i);
        rx_byte_i <= 8'h11;
        rx_load_i <= 1'b1;
        @(posedge clk_sys_i);
        rx_byte_i <= 8'h22;
        @(posedge clk_sys_i);
        rx_load_i <= 1'b0;
        bus_rd(8'h38);
        chk("overrun", 32'h0000_0042, got & 32'h0000_0042);
        bus_rd(8'h30);
        chk("rx byte", 32'h0000_0022, got);
        $display("test events done");
        // Second reset in mid-run clears mask and holding byte
        bus_wr(8'h24, 32'h0000_0F77);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus_rd(8'h2C);
        chk("mask after reset", 32'h0, got);
        bus_rd(8'h34);
        chk("tx after reset", 32'h0, got);
        $display("test reset done");
        wrap_up();
    end
    // Watchdog, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fails++;
        wrap_up();
    end
endmodule // ihr_regs_tb_top
